// ==== logic/pisr_pkg.sv ====
// Package of constants for the parallel-in serial-out shift register
// ==========================================================================
// ==========================================================================
package pisr_pkg;
  localparam int PISR_STAGES = 8;
  localparam int PISR_SYNC_DEPTH = 2;
  localparam logic [7:0] PISR_RESET_VALUE = 8'h00;
  localparam logic PISR_PIN_RESET = 1'b0;
endpackage : pisr_pkg

// ==== logic/pisr_sync.sv ====
// Two-flop synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
module pisr_sync (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic pin, // Asynchronous pin level
  output logic sync // Synchronised level
);
  import pisr_pkg::*;
  logic meta;
  // ========================================================================
  // Synchroniser: first flop read only by the second
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= PISR_PIN_RESET;
      sync <= PISR_PIN_RESET;
    end else begin
      meta <= pin;
      sync <= meta;
    end
  end
endmodule : pisr_sync
`default_nettype wire

// ==== logic/pisr_top.sv ====
// Parallel-in serial-out eight-stage shift register, sampled pin model
`timescale 1ns/1ps
`default_nettype none
module pisr_top #(
  parameter int STAGES = pisr_pkg::PISR_STAGES // Chain length
) (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic shift_not_load, // High shifts, low loads
  input wire logic clock, // Shift clock pin
  input wire logic clock_inhibit, // Inhibit pin, also a clock
  input wire logic serial_in, // Serial data into first stage
  input wire logic [STAGES-1:0] parallel_in, // Bit 0 is A, top is H
  output logic serial_out, // Last stage
  output logic serial_out_n // Complement of last stage
);
  import pisr_pkg::*;

  // ========================================================================
  // Pin synchronisers: all controls arrive from outside this clock
  // Every pin, data included, passes the same two flops, so a word and
  // the control level that qualifies it reach the logic in one cycle.
  // The price is latency: an output answers three clock edges after a
  // pin change (two synchroniser edges and one register edge).
  // Pin levels shorter than one clock period may be missed entirely;
  // the controller is expected to pace its pins well below this clock.
  localparam int NSYNC = STAGES + 4;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_s;
  assign pin_raw = {parallel_in, serial_in, clock_inhibit, clock,
                    shift_not_load};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      pisr_sync u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin(pin_raw[gi]),
        .sync(pin_s[gi])
      );
    end
  endgenerate

  logic load_n_s;
  logic clk_s;
  logic inh_s;
  logic ser_s;
  logic [STAGES-1:0] par_s;
  assign load_n_s = pin_s[0];
  assign clk_s = pin_s[1];
  assign inh_s = pin_s[2];
  assign ser_s = pin_s[3];
  assign par_s = pin_s[NSYNC-1:4];

  // ========================================================================
  // Warm-up after reset
  // The synchronisers and the edge flops all clear to zero, so a clock
  // pin that idles high would look like a fresh rising edge once its
  // sample arrives. Edges are ignored until every flop on that path
  // holds a real sample: two synchroniser edges and one edge flop.
  localparam logic [1:0] WARM_END = 2'(PISR_SYNC_DEPTH + 1);
  logic [1:0] warm_cnt;
  logic [1:0] next_warm_cnt;
  logic warm_done;

  // Count edges after reset and stop at the end value
  always_comb begin
    next_warm_cnt = warm_cnt;
    if (warm_cnt != WARM_END) begin
      next_warm_cnt = warm_cnt + 2'h1;
    end
  end

  // Shifting is allowed only once the count has run out
  assign warm_done = (warm_cnt == WARM_END);

  // Warm-up counter; loads still follow the pins during warm-up
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      warm_cnt <= 2'h0;
    end else begin
      warm_cnt <= next_warm_cnt;
    end
  end

  // ========================================================================
  // Shift strobe: previous levels of both clock pins
  logic clk_d;
  logic inh_d;
  logic shift_go;
  logic [STAGES-1:0] stages;
  logic [STAGES-1:0] next_stages;
  logic next_out;

  // Gated clock: either pin rises while the other is low; keeps
  // the inhibit pin from rising while clock is low unless a shift is meant
  always_comb begin
    shift_go = warm_done && load_n_s &&
               ((clk_s && !clk_d && !inh_s) ||
                (inh_s && !inh_d && !clk_s));
  end

  // Next stage contents
  always_comb begin
    next_stages = stages;
    if (!load_n_s) begin
      next_stages = par_s;
    end else if (shift_go) begin
      // Stage 0 is first; top stage drives the outputs
      next_stages = {stages[STAGES-2:0], ser_s};
    end // Load high: parallel data never looked at
    next_out = next_stages[STAGES-1];
  end

  // ========================================================================
  // Registers; outputs are flops mirroring the last stage
  // The outputs load from the next value of the last stage, so they
  // never lag the chain by a cycle and always agree with it.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stages <= PISR_RESET_VALUE[STAGES-1:0];
      clk_d <= PISR_PIN_RESET;
      inh_d <= PISR_PIN_RESET;
      serial_out <= PISR_RESET_VALUE[STAGES-1];
      serial_out_n <= !PISR_RESET_VALUE[STAGES-1];
    end else begin
      stages <= next_stages;
      clk_d <= clk_s;
      inh_d <= inh_s;
      serial_out <= next_out;
      serial_out_n <= !next_out;
    end
  end

  // ========================================================================
  // Assertions
  // Each |=> one watches the chain one edge after the decision taken by the
  // comb logic, so $past returns the synced inputs that decision used.

  // Load copies every synced parallel bit into its own stage
  a_load_copies: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !load_n_s |=> stages == $past(par_s))
    else $error("load did not copy parallel inputs");

  // Input A lands in the first stage, the one fed by the serial input
  a_first_from_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !load_n_s |=> stages[0] == $past(par_s[0]))
    else $error("first stage not loaded from A");

  // Input H reaches the outputs straight after a load
  a_top_from_h: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !load_n_s |=> serial_out == $past(par_s[STAGES-1]))
    else $error("last stage not loaded from H");

  // Every stage passes its content one step toward the outputs
  a_shift_moves: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    shift_go |=> stages == {$past(stages[STAGES-2:0]), $past(ser_s)})
    else $error("shift did not move chain");

  // The serial input fills the first stage on every shift
  a_ser_first: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    shift_go |=> stages[0] == $past(ser_s))
    else $error("serial input not captured");

  // One bit leaves per shift: the output takes the stage below it
  a_tail_moves: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    shift_go |=> serial_out == $past(stages[STAGES-2]))
    else $error("output did not take the next stage");

  // A clock held high freezes the chain whatever the inhibit pin does
  a_hold_clock: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    load_n_s && clk_s && clk_d |=> $stable(stages))
    else $error("contents changed while clock held high");

  // An inhibit held high freezes the chain whatever the clock does
  a_hold_inhibit: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    load_n_s && inh_s && inh_d |=> $stable(stages))
    else $error("contents changed while inhibit held high");

  // A clock edge with inhibit low shifts once warm-up is over
  a_clk_edge: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    warm_done && load_n_s && $rose(clk_s) && !inh_s |-> shift_go)
    else $error("clock edge did not shift");

  // The inhibit pin acts as the clock while the clock pin is low
  a_inh_edge: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    warm_done && load_n_s && $rose(inh_s) && !clk_s |-> shift_go)
    else $error("inhibit edge did not shift");

  // Without a shift, shift mode leaves the chain alone
  a_no_par_shift: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    load_n_s && !shift_go |=> $stable(stages))
    else $error("contents changed without shift");

  // New parallel data in shift mode must not reach the chain
  a_par_ignored: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    load_n_s && $changed(par_s) && !shift_go |=> $stable(stages))
    else $error("parallel data taken in shift mode");

  // Outputs stand until the next load or shift
  a_out_hold: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    load_n_s && !shift_go |=> $stable(serial_out) && $stable(serial_out_n))
    else $error("serial outputs moved without a shift");

  // The true output follows the last stage
  a_out_pair: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    serial_out == stages[STAGES-1])
    else $error("serial output not the last stage");

  // The second output is always the complement of the first
  a_out_compl: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    serial_out_n == !serial_out)
    else $error("serial outputs not complementary");
endmodule : pisr_top
`default_nettype wire

// ==== tb/pisr_ctrl.sv ====
// Controller model that drives the register pins
`timescale 1ns/1ps
`default_nettype none
module pisr_ctrl (
  input wire logic clk_sys, // System clock
  output logic shift_not_load, // Low loads
  output logic clock, // Shift clock
  output logic clock_inhibit, // Inhibit, also a clock
  output logic serial_in, // Serial data
  output logic [7:0] parallel_in // Parallel word
);
  // ========================================
  // Pin step
  // Change just after an edge, hold 4 edges: sync needs 3
  task automatic step(input logic [11:0] v);
    @(posedge clk_sys);
    {shift_not_load, clock, clock_inhibit, serial_in, parallel_in} <= v;
    repeat (4) @(posedge clk_sys);
  endtask : step
  // Idle in load with the clock high, so inhibit may rise safely
  initial begin
    {shift_not_load, clock, clock_inhibit, serial_in,
     parallel_in} = 12'h400;
  end
endmodule : pisr_ctrl
`default_nettype wire

// ==== tb/pisr_top_bench.sv ====
// Self-checking bench for the shift register
`timescale 1ns/1ps
`default_nettype none
module pisr_top_bench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic sl, ck, inh, si, so, so_n;
  logic [7:0] par;
  int fail_count = 0;
  int checked = 0;
  pisr_ctrl u_pisr_ctrl (.clk_sys(clk_sys), .shift_not_load(sl), .clock(ck),
    .clock_inhibit(inh), .serial_in(si), .parallel_in(par));
  pisr_top u_pisr_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .shift_not_load(sl), .clock(ck), .clock_inhibit(inh), .serial_in(si),
    .parallel_in(par), .serial_out(so), .serial_out_n(so_n));
  // ========================================
  // Clock and checks
  always #4 clk_sys = ~clk_sys;
  // Look off the edge, once the outputs have settled
  task automatic chk(input logic e);
    #2;
    checked++;
    if (so !== e || so_n !== ~e) begin
      fail_count++;
      $display("[ERR] %0t serial out %b/%b want %b", $time, so, so_n, e);
    end
  endtask : chk
  task automatic st(input logic [11:0] v);
    u_pisr_ctrl.step(v);
  endtask : st
  // Load follows the inputs as a level, whatever the clocks do
  task automatic t_load();
    st(12'h0A5); chk(1'b1);
    st(12'h63C); chk(1'b0);
  endtask : t_load
  // Seven shifts bring G..A, the eighth the first serial bit
  task automatic t_shift();
    logic [7:0] w;
    w = 8'h3C;
    st(12'h83C); chk(1'b0);
    st(12'h8C3); chk(1'b0);
    for (int n = 0; n < 8; n++) begin
      st(12'hDFF);
      st(12'h9FF);
      chk(n < 7 ? w[6-n] : 1'b1);
    end
  endtask : t_shift
  // Inhibit holds the data; a lone inhibit rise also shifts
  task automatic t_inhibit();
    st(12'h0A5); st(12'h4A5); st(12'h6A5); st(12'hEA5);
    st(12'hAA5); st(12'hEA5); chk(1'b1);
    st(12'hAA5); st(12'h8A5); chk(1'b1);
    st(12'hAA5); chk(1'b0);
  endtask : t_inhibit
  task automatic close_out();
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  // Whole run is about 160 cycles; 20 us is ample
  initial begin
    #20000;
    fail_count++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_load();
    t_shift();
    t_inhibit();
    close_out();
  end
endmodule : pisr_top_bench
`default_nettype wire
